// file: ispfc_consts.svh
`ifndef ISPFC_CONSTS_SVH
`define ISPFC_CONSTS_SVH
`define ISPFC_OFS_CHIP_CTRL      8'hbf
`define ISPFC_OFS_WRITE_UNLOCK   8'hc6
`define ISPFC_OFS_ROM_OP_CTRL    8'hc7
`define ISPFC_OFS_ADDR_HIGH      8'hc5
`define ISPFC_OFS_ADDR_LOW       8'hc4
`define ISPFC_OFS_PROG_DATA      8'hc3
`define ISPFC_OFS_STATUS         8'hc2
`define ISPFC_UNLOCK_FIRST       8'h87
`define ISPFC_UNLOCK_SECOND      8'h59
`define ISPFC_BIT_REBOOT         7
`define ISPFC_BIT_AUX_RAM        4
`define ISPFC_BIT_BOOT_SEL       1
`define ISPFC_BIT_PROG_EN        0
`define ISPFC_BIT_BANK_SEL       6
`define ISPFC_BIT_OE             5
`define ISPFC_BIT_CE             4
`define ISPFC_CODE_ERASE         4'h2
`define ISPFC_CODE_PROGRAM       4'h1
`define ISPFC_CODE_READ          4'h0
`define ISPFC_CHIP_CTRL_RESET    8'h00
`define ISPFC_ROM_OP_RESET       8'h30
`define ISPFC_OP_TIME_NS         200
`define ISPFC_CLK_PERIOD_NS      40
`define ISPFC_OP_CYCLES          ((`ISPFC_OP_TIME_NS + `ISPFC_CLK_PERIOD_NS - 1) / `ISPFC_CLK_PERIOD_NS)
`define ISPFC_REBOOT_CYCLES      8'h10
`endif

// file: ispfc_pkg.sv
package ispfc_pkg;
  typedef enum logic [1:0] {
    ISPFC_LOCKED  = 2'b00,
    ISPFC_ARMED   = 2'b01,
    ISPFC_OPEN    = 2'b10
  } ispfc_unlock_type;

  typedef enum logic [2:0] {
    ISPFC_NORMAL  = 3'b000,
    ISPFC_WAIT_WK = 3'b001,
    ISPFC_PROG    = 3'b010,
    ISPFC_OP_RUN  = 3'b011,
    ISPFC_REBOOT  = 3'b100
  } ispfc_mode_type;

  typedef enum logic [1:0] {
    ISPFC_OP_NONE  = 2'b00,
    ISPFC_OP_ERASE = 2'b01,
    ISPFC_OP_PROG  = 2'b10,
    ISPFC_OP_READ  = 2'b11
  } ispfc_op_type;

  typedef struct packed {
    logic        req;
    logic        bank;
    ispfc_op_type op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ispfc_rom_req_type;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } ispfc_rom_rsp_type;
endpackage

// file: ispfc_strap_sync.sv
`timescale 1ns/1ps
module ispfc_strap_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } ispfc_sync_type;

  ispfc_sync_type st_reg;
  ispfc_sync_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // change taken only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '{default: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
endmodule // ispfc_strap_sync

// file: ispfc_isp_flash_controller.sv
`timescale 1ns/1ps
`include "ispfc_consts.svh"
// Functional notes
// [R1] normal mode fetches from application bank unless programming or reboot selects otherwise
// [R2] chip control read-only after reset; 87h then 59h to unlock opens it
// [R3] any other unlock write value closes chip control write access again
// [R4] all programming operations happen only while the cpu sits in idle
// [R5] software bounds idle with a timer interrupt so operations can finish
// [R6] target address comes from high and low byte registers
// [R7] data register feeds program writes and captures read results
// [R8] operation control bit 6 picks main bank (0) or auxiliary bank (1)
// [R9] codes decoded with chip enable low: 0010 erase, 0001 program, 0000 read
// [R10] reboot bit with boot select and programming enable resets the core
// [R11] reboot bit reads one while forced loader boot is active
// [R12] chip control bit 4 enables auxiliary ram
// [R13] chip control bit 1 swaps loader and target bank roles
// [R14] programming enable plus idle then wakeup enters programming mode
// [R15] with programming enable clear, erase and program are blocked
// [R16] chip control writes while locked are ignored
// [R17] power-on boots application bank unless reset straps force loader boot
module ispfc_isp_flash_controller #(
  parameter int OP_CYCLES = `ISPFC_OP_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        cpu_idle,
  input  wire logic                        cpu_wakeup,
  input  wire logic                        strap_p43,
  input  wire logic                        strap_p27,
  input  wire logic                        strap_p26,
  output ispfc_pkg::ispfc_rom_req_type     rom_req,
  input  wire ispfc_pkg::ispfc_rom_rsp_type rom_rsp,
  output logic                             fetch_from_loader,
  output logic                             isp_mode,
  output logic                             aux_ram_enable,
  output logic                             core_reset_n
);
  initial begin
    if (OP_CYCLES < 1 || OP_CYCLES > 255) $error("OP_CYCLES out of range");
  end

  typedef struct packed {
    ispfc_pkg::ispfc_unlock_type lock;
    ispfc_pkg::ispfc_mode_type   mode;
    logic                        forced_loader_boot;
    logic                        strap_taken;
    logic                        aux_ram_enable;
    logic                        boot_location_select;
    logic                        programming_enable;
    logic [7:0]                  rom_operation_control;
    logic [7:0]                  target_address_high;
    logic [7:0]                  target_address_low;
    logic [7:0]                  programming_data;
    logic [7:0]                  op_count;
    logic [7:0]                  reboot_count;
    logic                        op_blocked;
    ispfc_pkg::ispfc_rom_req_type req;
    logic [7:0]                  rdata;
  } ispfc_state_type;

  ispfc_state_type st_reg;
  ispfc_state_type st_next;
  logic [2:0]      strap_lvl;

  ispfc_strap_sync #(
    .WIDTH     (3)
  ) u_strap (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({strap_p43, strap_p27, strap_p26}),
    .level_out (strap_lvl)
  );

  function automatic ispfc_pkg::ispfc_op_type decode_op(input logic [7:0] ctl);
    decode_op = ispfc_pkg::ISPFC_OP_NONE;
    if (!ctl[`ISPFC_BIT_CE]) begin // [R9]
      if (ctl[3:0] == `ISPFC_CODE_ERASE && ctl[`ISPFC_BIT_OE]) begin
        decode_op = ispfc_pkg::ISPFC_OP_ERASE;
      end else if (ctl[3:0] == `ISPFC_CODE_PROGRAM && ctl[`ISPFC_BIT_OE]) begin
        decode_op = ispfc_pkg::ISPFC_OP_PROG;
      end else if (ctl[3:0] == `ISPFC_CODE_READ && !ctl[`ISPFC_BIT_OE]) begin
        decode_op = ispfc_pkg::ISPFC_OP_READ;
      end
    end
  endfunction

  function automatic logic [7:0] chip_ctrl_view(input ispfc_state_type s);
    chip_ctrl_view = 8'h00;
    chip_ctrl_view[`ISPFC_BIT_REBOOT]   = s.forced_loader_boot; // [R11]
    chip_ctrl_view[`ISPFC_BIT_AUX_RAM]  = s.aux_ram_enable;
    chip_ctrl_view[`ISPFC_BIT_BOOT_SEL] = s.boot_location_select;
    chip_ctrl_view[`ISPFC_BIT_PROG_EN]  = s.programming_enable;
  endfunction

  logic                     wr_chip;
  logic                     wr_unlock;
  ispfc_pkg::ispfc_op_type  op_dec;

  always_comb begin
    st_next     = st_reg;
    st_next.req.req = 1'b0;
    wr_chip     = reg_wr && reg_addr == `ISPFC_OFS_CHIP_CTRL;
    wr_unlock   = reg_wr && reg_addr == `ISPFC_OFS_WRITE_UNLOCK;
    op_dec      = decode_op(st_reg.rom_operation_control);

    // straps are caught once, after the synchroniser has settled
    if (!st_reg.strap_taken && st_reg.reboot_count == 8'h00) begin
      st_next.strap_taken        = 1'b1;
      st_next.forced_loader_boot = ~strap_lvl[2] | (~strap_lvl[1] & ~strap_lvl[0]); // [R17]
    end

    if (wr_unlock) begin
      case (st_reg.lock)
        ispfc_pkg::ISPFC_LOCKED: begin
          st_next.lock = (reg_wdata == `ISPFC_UNLOCK_FIRST) ? ispfc_pkg::ISPFC_ARMED
                                                             : ispfc_pkg::ISPFC_LOCKED; // [R2]
        end
        ispfc_pkg::ISPFC_ARMED: begin
          st_next.lock = (reg_wdata == `ISPFC_UNLOCK_SECOND) ? ispfc_pkg::ISPFC_OPEN
                                                              : ispfc_pkg::ISPFC_LOCKED; // [R2] [R3]
        end
        default: begin
          st_next.lock = ispfc_pkg::ISPFC_LOCKED; // [R3]
        end
      endcase
    end

    // locked writes fall through untouched
    if (wr_chip && st_reg.lock == ispfc_pkg::ISPFC_OPEN) begin // [R16]
      st_next.aux_ram_enable       = reg_wdata[`ISPFC_BIT_AUX_RAM]; // [R12]
      st_next.boot_location_select = reg_wdata[`ISPFC_BIT_BOOT_SEL]; // [R13]
      st_next.programming_enable   = reg_wdata[`ISPFC_BIT_PROG_EN];
      if (reg_wdata[`ISPFC_BIT_REBOOT] && reg_wdata[`ISPFC_BIT_BOOT_SEL]
          && reg_wdata[`ISPFC_BIT_PROG_EN]) begin
        st_next.mode         = ispfc_pkg::ISPFC_REBOOT; // [R10]
        st_next.reboot_count = `ISPFC_REBOOT_CYCLES;
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        `ISPFC_OFS_ROM_OP_CTRL: st_next.rom_operation_control = reg_wdata;
        `ISPFC_OFS_ADDR_HIGH:   st_next.target_address_high   = reg_wdata; // [R6]
        `ISPFC_OFS_ADDR_LOW:    st_next.target_address_low    = reg_wdata; // [R6]
        `ISPFC_OFS_PROG_DATA:   st_next.programming_data      = reg_wdata; // [R7]
        default: begin
        end
      endcase
    end

    case (st_reg.mode)
      ispfc_pkg::ISPFC_NORMAL: begin
        if (st_reg.programming_enable && cpu_idle) begin
          st_next.mode = ispfc_pkg::ISPFC_WAIT_WK; // [R14]
        end
      end
      ispfc_pkg::ISPFC_WAIT_WK: begin
        if (!st_reg.programming_enable) begin
          st_next.mode = ispfc_pkg::ISPFC_NORMAL;
        end else if (cpu_wakeup) begin
          st_next.mode = ispfc_pkg::ISPFC_PROG; // [R14]
        end
      end
      ispfc_pkg::ISPFC_PROG: begin
        if (!st_reg.programming_enable && cpu_idle) begin
          st_next.mode = ispfc_pkg::ISPFC_NORMAL; // [R4]
          // exit wins over the op, so a refused erase or program is still flagged
          st_next.op_blocked = (op_dec == ispfc_pkg::ISPFC_OP_ERASE)
                               || (op_dec == ispfc_pkg::ISPFC_OP_PROG); // [R15]
        end else if (cpu_idle && op_dec != ispfc_pkg::ISPFC_OP_NONE) begin // [R4]
          if (!st_reg.programming_enable && op_dec != ispfc_pkg::ISPFC_OP_READ) begin
            st_next.op_blocked = 1'b1; // [R15]
          end else begin
            st_next.op_blocked  = 1'b0;
            st_next.mode        = ispfc_pkg::ISPFC_OP_RUN;
            st_next.op_count    = 8'(OP_CYCLES);
            st_next.req.req     = 1'b1;
            st_next.req.op      = op_dec;
            st_next.req.bank    = st_reg.rom_operation_control[`ISPFC_BIT_BANK_SEL]; // [R8]
            st_next.req.addr    = {st_reg.target_address_high, st_reg.target_address_low};
            st_next.req.wdata   = st_reg.programming_data; // [R7]
          end
        end
      end
      ispfc_pkg::ISPFC_OP_RUN: begin
        if (st_reg.op_count != 8'h00) begin
          st_next.op_count = st_reg.op_count - 8'h01;
        end
        if (rom_rsp.done && st_reg.req.op == ispfc_pkg::ISPFC_OP_READ) begin
          st_next.programming_data = rom_rsp.rdata; // [R7]
        end
        // leave on the response or the minimum op time, whichever comes first, once the cpu is out of idle
        if ((rom_rsp.done || st_reg.op_count == 8'h00) && !cpu_idle) begin
          st_next.mode = ispfc_pkg::ISPFC_PROG;
        end
      end
      ispfc_pkg::ISPFC_REBOOT: begin
        st_next.reboot_count = st_reg.reboot_count - 8'h01;
        if (st_reg.reboot_count == 8'h01) begin
          st_next.mode                 = ispfc_pkg::ISPFC_NORMAL; // [R10]
          st_next.lock                 = ispfc_pkg::ISPFC_LOCKED;
          st_next.forced_loader_boot   = 1'b0;
          st_next.programming_enable   = 1'b0;
          st_next.boot_location_select = 1'b0;
          st_next.aux_ram_enable       = 1'b0;
          st_next.rom_operation_control = `ISPFC_ROM_OP_RESET;
          st_next.op_blocked           = 1'b0;
        end
      end
      default: begin
        st_next.mode = ispfc_pkg::ISPFC_NORMAL;
      end
    endcase

    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ISPFC_OFS_CHIP_CTRL:   st_next.rdata = chip_ctrl_view(st_reg);
        `ISPFC_OFS_ROM_OP_CTRL: st_next.rdata = {1'b0, st_reg.rom_operation_control[6:0]};
        `ISPFC_OFS_ADDR_HIGH:   st_next.rdata = st_reg.target_address_high;
        `ISPFC_OFS_ADDR_LOW:    st_next.rdata = st_reg.target_address_low;
        `ISPFC_OFS_PROG_DATA:   st_next.rdata = st_reg.programming_data;
        `ISPFC_OFS_STATUS:      st_next.rdata = {4'h0, st_reg.op_blocked,
                                                 st_reg.mode};
        default:                st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg                       <= '0;
      st_reg.lock                  <= ispfc_pkg::ISPFC_LOCKED; // [R2]
      st_reg.mode                  <= ispfc_pkg::ISPFC_NORMAL;
      st_reg.rom_operation_control <= `ISPFC_ROM_OP_RESET;
      st_reg.reboot_count          <= 8'h04;
    end else begin
      if (st_reg.reboot_count != 8'h00 && st_reg.mode == ispfc_pkg::ISPFC_NORMAL) begin
        st_reg              <= st_next;
        st_reg.reboot_count <= st_reg.reboot_count - 8'h01;
      end else begin
        st_reg <= st_next;
      end
    end
  end

  assign reg_rdata         = st_reg.rdata;
  assign rom_req           = st_reg.req;
  assign isp_mode          = st_reg.mode == ispfc_pkg::ISPFC_PROG
                             || st_reg.mode == ispfc_pkg::ISPFC_OP_RUN;
  // loader fetch when forced, or in programming mode with loader in aux bank
  assign fetch_from_loader = st_reg.forced_loader_boot
                             || (isp_mode && st_reg.boot_location_select); // [R1] [R13]
  assign aux_ram_enable    = st_reg.aux_ram_enable; // [R12]
  assign core_reset_n      = st_reg.mode != ispfc_pkg::ISPFC_REBOOT; // [R10]

  property p_unlock_seq;
    @(posedge clk) disable iff (!rst_n)
      (wr_unlock && reg_wdata == `ISPFC_UNLOCK_SECOND && st_reg.lock == ispfc_pkg::ISPFC_ARMED)
      |=> st_reg.lock == ispfc_pkg::ISPFC_OPEN;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock sequence failed"); // [R2]

  property p_bad_close;
    @(posedge clk) disable iff (!rst_n)
      (wr_unlock && reg_wdata != `ISPFC_UNLOCK_FIRST && reg_wdata != `ISPFC_UNLOCK_SECOND)
      |=> st_reg.lock == ispfc_pkg::ISPFC_LOCKED;
  endproperty
  a_bad_close: assert property (p_bad_close) else $error("bad unlock value kept access"); // [R3]

  property p_locked_ignore;
    @(posedge clk) disable iff (!rst_n)
      (wr_chip && st_reg.lock != ispfc_pkg::ISPFC_OPEN && st_reg.mode != ispfc_pkg::ISPFC_REBOOT)
      |=> $stable(st_reg.programming_enable) && $stable(st_reg.aux_ram_enable);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked write changed bits"); // [R16]

  property p_op_in_idle;
    @(posedge clk) disable iff (!rst_n)
      rom_req.req |-> $past(cpu_idle);
  endproperty
  a_op_in_idle: assert property (p_op_in_idle) else $error("op started outside idle"); // [R4]

  property p_blocked;
    @(posedge clk) disable iff (!rst_n)
      (rom_req.req && rom_req.op != ispfc_pkg::ISPFC_OP_READ) |-> $past(st_reg.programming_enable);
  endproperty
  a_blocked: assert property (p_blocked) else $error("write op without enable"); // [R15]

  property p_addr;
    @(posedge clk) disable iff (!rst_n)
      rom_req.req |-> rom_req.addr == $past({st_reg.target_address_high, st_reg.target_address_low})
                      && rom_req.bank == $past(st_reg.rom_operation_control[6]);
  endproperty
  a_addr: assert property (p_addr) else $error("wrong address or bank"); // [R6] [R8]

  sequence s_reboot_req;
    wr_chip && st_reg.lock == ispfc_pkg::ISPFC_OPEN && reg_wdata[7] && reg_wdata[1] && reg_wdata[0];
  endsequence
  property p_reboot;
    @(posedge clk) disable iff (!rst_n)
      s_reboot_req |=> !core_reset_n [*8];
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot pulse too short"); // [R10]

  property p_isp_entry;
    @(posedge clk) disable iff (!rst_n)
      (st_reg.mode == ispfc_pkg::ISPFC_WAIT_WK && cpu_wakeup && st_reg.programming_enable)
      |=> isp_mode;
  endproperty
  a_isp_entry: assert property (p_isp_entry) else $error("no entry after wakeup"); // [R14]
endmodule // ispfc_isp_flash_controller

// file: isp_flash_controller_test.sv
`timescale 1ns/1ps
`include "ispfc_consts.svh"
`define CHECK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module isp_flash_controller_test;
  localparam int OP_CYCLES = 5;
  logic                          clk        = 1'b0;
  logic                          rst_n      = 1'b0;
  logic [7:0]                    reg_addr   = 8'h00;
  logic [7:0]                    reg_wdata  = 8'h00;
  logic                          reg_wr     = 1'b0;
  logic                          reg_rd     = 1'b0;
  logic [7:0]                    reg_rdata;
  logic                          cpu_idle   = 1'b0;
  logic                          cpu_wakeup = 1'b0;
  logic                          strap_p43  = 1'b1;
  logic                          strap_p27  = 1'b1;
  logic                          strap_p26  = 1'b1;
  ispfc_pkg::ispfc_rom_req_type  rom_req;
  ispfc_pkg::ispfc_rom_rsp_type  rom_rsp    = '0;
  logic                          fetch_from_loader;
  logic                          isp_mode;
  logic                          aux_ram_enable;
  logic                          core_reset_n;
  int                            err_total   = 0;
  int                            checks_done = 0;
  int                            cycles      = 0;
  logic [7:0]                    rd_val;

  ispfc_isp_flash_controller #(.OP_CYCLES(OP_CYCLES)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
    .cpu_wakeup(cpu_wakeup), .strap_p43(strap_p43), .strap_p27(strap_p27),
    .strap_p26(strap_p26), .rom_req(rom_req), .rom_rsp(rom_rsp),
    .fetch_from_loader(fetch_from_loader), .isp_mode(isp_mode),
    .aux_ram_enable(aux_ram_enable), .core_reset_n(core_reset_n)
  );

  always #20 clk = ~clk;

  // memory answers one cycle after each request; data differs when idle
  always @(posedge clk) begin
    rom_rsp.done  <= rom_req.req;
    rom_rsp.rdata <= rom_req.req ? 8'ha5 : 8'h5a;
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic do_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    // step past the edge so callers see the registered result
    #1;
  endtask

  // data stand only in the cycle after the strobe, so sample inside it
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic unlock;
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, `ISPFC_UNLOCK_FIRST);
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, `ISPFC_UNLOCK_SECOND);
  endtask

  task automatic run_op(input logic [7:0] ctrl, input logic exp_req,
                        input ispfc_pkg::ispfc_op_type exp_op, input logic exp_bank);
    logic seen;
    seen = 1'b0;
    reg_write(`ISPFC_OFS_ROM_OP_CTRL, ctrl);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1;
      `CHECK(rom_req.req, 1'b0)
    end
    @(posedge clk) cpu_idle <= 1'b1;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clk);
      #1;
      if (rom_req.req === 1'b1) seen = 1'b1;
    end
    `CHECK(seen, exp_req)
    if (seen) begin
      `CHECK(rom_req.op, exp_op)
      `CHECK(rom_req.bank, exp_bank)
      `CHECK(rom_req.addr, 16'h12c4)
      `CHECK(rom_req.wdata, 8'h3c)
      @(posedge clk);
      #1;
      `CHECK(rom_req.req, 1'b0)
    end
    repeat (OP_CYCLES + 2) @(posedge clk);
    cpu_idle <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    int n;
    do_reset();
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, `ISPFC_CHIP_CTRL_RESET)
    reg_read(`ISPFC_OFS_ROM_OP_CTRL, rd_val);
    `CHECK(rd_val, `ISPFC_ROM_OP_RESET)
    `CHECK(fetch_from_loader, 1'b0)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h13);
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h00)
    // a stray value between the two unlock values must spoil the sequence
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, `ISPFC_UNLOCK_FIRST);
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, 8'h00);
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, `ISPFC_UNLOCK_SECOND);
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h10);
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h00)
    unlock();
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h10);
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h10)
    `CHECK(aux_ram_enable, 1'b1)
    reg_write(`ISPFC_OFS_WRITE_UNLOCK, 8'h33);
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h00);
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h10)
    unlock();
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h00);
    `CHECK(aux_ram_enable, 1'b0)
    reg_write(`ISPFC_OFS_ADDR_HIGH, 8'h12);
    reg_write(`ISPFC_OFS_ADDR_LOW, 8'hc4);
    reg_write(`ISPFC_OFS_PROG_DATA, 8'h3c);
    reg_read(`ISPFC_OFS_ADDR_HIGH, rd_val);
    `CHECK(rd_val, 8'h12)
    reg_read(`ISPFC_OFS_ADDR_LOW, rd_val);
    `CHECK(rd_val, 8'hc4)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h11);
    @(posedge clk) cpu_idle <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHECK(isp_mode, 1'b0)
    @(posedge clk) cpu_wakeup <= 1'b1;
    @(posedge clk);
    cpu_wakeup <= 1'b0;
    cpu_idle   <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(isp_mode, 1'b1)
    `CHECK(fetch_from_loader, 1'b0)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h13);
    `CHECK(fetch_from_loader, 1'b1)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h11);
    run_op(8'h41, 1'b0, ispfc_pkg::ISPFC_OP_NONE, 1'b0);
    run_op(8'h32, 1'b0, ispfc_pkg::ISPFC_OP_NONE, 1'b0);
    run_op(8'h22, 1'b1, ispfc_pkg::ISPFC_OP_ERASE, 1'b0);
    run_op(8'h61, 1'b1, ispfc_pkg::ISPFC_OP_PROG, 1'b1);
    run_op(8'h00, 1'b1, ispfc_pkg::ISPFC_OP_READ, 1'b0);
    reg_read(`ISPFC_OFS_PROG_DATA, rd_val);
    `CHECK(rd_val, 8'ha5)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h10);
    run_op(8'h22, 1'b0, ispfc_pkg::ISPFC_OP_NONE, 1'b0);
    reg_read(`ISPFC_OFS_STATUS, rd_val);
    `CHECK(rd_val, 8'h08)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h83);
    n = 0;
    // first sample falls just after the edge that took the write
    for (int i = 0; i < 40; i++) begin
      if (core_reset_n === 1'b0) n++;
      @(posedge clk);
      #1;
    end
    `CHECK(n, int'(`ISPFC_REBOOT_CYCLES))
    reg_read(`ISPFC_OFS_STATUS, rd_val);
    `CHECK(rd_val, 8'h00)
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h00)
    reg_write(`ISPFC_OFS_CHIP_CTRL, 8'h01);
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h00)
    `CHECK(fetch_from_loader, 1'b0)
    for (int k = 0; k < 2; k++) begin
      strap_p43 <= (k == 1);
      strap_p27 <= (k == 0);
      strap_p26 <= (k == 0);
      do_reset();
      reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
      `CHECK(rd_val[7], 1'b1)
      `CHECK(fetch_from_loader, 1'b1)
    end
    strap_p27 <= 1'b1;
    strap_p26 <= 1'b1;
    do_reset();
    reg_read(`ISPFC_OFS_CHIP_CTRL, rd_val);
    `CHECK(rd_val, 8'h00)
    complete_run();
  end
endmodule // isp_flash_controller_test
